// ### hw/desync_pkg.sv
// Functional notes
// [RULE1] first burst: seven pulses, one gap
// [RULE2] pulse period one STS-1 clock
// [RULE3] second burst: five pulses, one gap
// [RULE4] major A: 63 sevens, 36 fives
// [RULE5] third burst: six pulses, no gap
// [RULE6] major B: 63 sevens, 35 fives, one six
// [RULE7] super pattern: A, A, B, repeat
// [RULE8] 1864 pulses per 2160 periods
// [RULE9] channel takes pattern, emits smoothed DS3
// [RULE10] tolerate 59 missing pulses in a row
// [RULE11] fast relock disable only by register
// [RULE12] control bits: relock, clear, bandwidth, path
// [RULE13] fast relock reacquires well within 50 ms
// [RULE14] mapper pre-processes clock into super pattern
// [RULE15] data sampled on gapped clock rising edge
// [RULE16] bw hi 0, lo 1 selects narrow
// [RULE17] gap holds clock idle, data steady
`default_nettype none
package desync_pkg;
   localparam logic [7:0] CTRL_OFFSET      = 8'h17;
   localparam logic [7:0] CTRL_RESET       = 8'h01;
   localparam logic [7:0] CTRL_RW_MASK     = 8'h1F;
   localparam int         BIT_BW_LO        = 0;
   localparam int         BIT_IN_TX_PATH   = 1;
   localparam int         BIT_BW_HI        = 2;
   localparam int         BIT_BUF_CLEAR    = 3;
   localparam int         BIT_RELOCK_DIS   = 4;
   localparam logic [7:0] STATUS_OFFSET    = 8'h18;
   localparam logic [7:0] COUNT_OFFSET     = 8'h19;
   localparam int         SEVEN_PULSES     = 7;
   localparam int         FIVE_PULSES      = 5;
   localparam int         SIX_PULSES       = 6;
   localparam int         SEVEN_REPEATS    = 63;
   localparam int         FIVE_REPEATS_A   = 36;
   localparam int         FIVE_REPEATS_B   = 35;
   localparam int         MAJOR_A_COUNT    = 2;
   localparam int         SUPER_PULSES     = 1864;
   localparam int         SUPER_PERIODS    = 2160;
   localparam int         MAX_GAP_BITS     = 59;
   localparam int         CLK_MHZ          = 100;
   localparam int         DS3_KHZ          = 44736;
   localparam int         RELOCK_MS        = 50;
   // fast relock window: a tenth of the 50 ms limit
   localparam int         RELOCK_FAST_CYC  = RELOCK_MS * CLK_MHZ * 100;
   localparam int         RELOCK_SLOW_CYC  = RELOCK_MS * CLK_MHZ * 1000 * 4;
   localparam logic [1:0] BW_NARROW        = 2'b01;
endpackage
`default_nettype wire

// ### hw/desync_link_if.sv
`default_nettype none
interface desync_link_if;
   logic tx_gapped_clock_in;
   logic tx_positive_data_in;
   modport mapper (output tx_gapped_clock_in, output tx_positive_data_in);
   modport channel (input tx_gapped_clock_in, input tx_positive_data_in);
endinterface
`default_nettype wire

// ### hw/super_pattern_gen.sv
`default_nettype none
module super_pattern_gen
   import desync_pkg::*;
#(
   parameter int DIV = 2
) (
   input  wire logic  core_clk_i,
   input  wire logic  srst_i,
   input  wire logic  enable_i,
   input  wire logic  data_i,
   output logic       data_taken_o,
   output logic       super_start_o,
   desync_link_if.mapper link
);
   typedef enum logic [2:0] {
      PH_SEVEN = 3'b001,
      PH_FIVE  = 3'b010,
      PH_SIX   = 3'b100
   } phase_e;

   phase_e     phase, next_phase;
   logic [7:0] div_cnt, next_div_cnt;
   logic [2:0] slot, next_slot;
   logic [5:0] rep, next_rep;
   logic [1:0] major, next_major;
   logic       clk_q, next_clk_q;
   logic       dat_q, next_dat_q;
   logic       pulse_slot;
   logic       last_slot;
   logic       last_rep;
   logic       tick_rise, tick_fall;

   always_comb begin
      next_div_cnt = div_cnt;
      next_phase   = phase;
      next_slot    = slot;
      next_rep     = rep;
      next_major   = major;
      next_clk_q   = clk_q;
      next_dat_q   = dat_q;
      tick_rise    = enable_i && (div_cnt == 8'h00);
      tick_fall    = enable_i && (div_cnt == 8'((DIV + 1) / 2));
      pulse_slot   = 1'b1;
      last_slot    = 1'b0;
      last_rep     = 1'b0;
      // [RULE2] one pulse per link period
      if (enable_i) begin
         next_div_cnt = (div_cnt == 8'(DIV * 2 - 1)) ? 8'h00 : div_cnt + 8'h01;
      end
      unique case (phase)
         // [RULE1] seven then gap
         PH_SEVEN: begin
            pulse_slot = (slot < 3'(SEVEN_PULSES));
            last_slot  = (slot == 3'(SEVEN_PULSES));
            last_rep   = (rep == 6'(SEVEN_REPEATS - 1));
         end
         // [RULE3] five then gap
         PH_FIVE: begin
            pulse_slot = (slot < 3'(FIVE_PULSES));
            last_slot  = (slot == 3'(FIVE_PULSES));
            // [RULE4] [RULE6] 36 in A, 35 in B
            last_rep   = (major == 2'(MAJOR_A_COUNT))
                         ? (rep == 6'(FIVE_REPEATS_B - 1))
                         : (rep == 6'(FIVE_REPEATS_A - 1));
         end
         // [RULE5] six gapless
         PH_SIX: begin
            pulse_slot = 1'b1;
            last_slot  = (slot == 3'(SIX_PULSES - 1));
            last_rep   = 1'b1;
         end
      endcase
      if (tick_rise) begin
         // [RULE17] gap keeps clock low, data held
         if (pulse_slot) begin
            next_clk_q = 1'b1;
            next_dat_q = data_i;
         end
         next_slot = slot + 3'h1;
         if (last_slot) begin
            next_slot = 3'h0;
            next_rep  = rep + 6'h01;
            if (last_rep) begin
               next_rep = 6'h00;
               unique case (phase)
                  PH_SEVEN: next_phase = PH_FIVE;
                  PH_FIVE: begin
                     next_phase = (major == 2'(MAJOR_A_COUNT)) ? PH_SIX : PH_SEVEN;
                     if (major != 2'(MAJOR_A_COUNT)) begin
                        next_major = major + 2'h1;
                     end
                  end
                  // [RULE7] A, A, B then restart
                  PH_SIX: begin
                     next_phase = PH_SEVEN;
                     next_major = 2'h0;
                  end
               endcase
            end
         end
      end else if (tick_fall || !enable_i) begin
         // stopping mid-pulse must not leave the clock high
         next_clk_q = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         div_cnt <= 8'h00;
         phase   <= PH_SEVEN;
         slot    <= 3'h0;
         rep     <= 6'h00;
         major   <= 2'h0;
         clk_q   <= 1'b0;
         dat_q   <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         phase   <= next_phase;
         slot    <= next_slot;
         rep     <= next_rep;
         major   <= next_major;
         clk_q   <= next_clk_q;
         dat_q   <= next_dat_q;
      end
   end

   // [RULE14] pre-processed clock onto link
   assign link.tx_gapped_clock_in  = clk_q;
   assign link.tx_positive_data_in = dat_q;
   assign data_taken_o  = tick_rise && pulse_slot;
   // [RULE8] start of each 2160-period pattern
   assign super_start_o = tick_rise && phase == PH_SEVEN && slot == 3'h0
                          && rep == 6'h00 && major == 2'h0;
endmodule
`default_nettype wire

// ### hw/desync_channel.sv
// Added by the designer: the address-and-strobe port.
`default_nettype none
module desync_channel
   import desync_pkg::*;
#(
   parameter int ACC_W       = 16,
   parameter int RELOCK_FAST = RELOCK_FAST_CYC,
   parameter int RELOCK_SLOW = RELOCK_SLOW_CYC
) (
   input  wire logic  core_clk_i,
   input  wire logic  srst_i,
   input  wire logic  host_mode_i,
   input  wire logic  protect_switch_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic  wr_i,
   input  wire logic  rd_i,
   output logic [7:0] rdata_o,
   output logic       ds3_data_o,
   output logic       ds3_strobe_o,
   output logic       locked_o,
   desync_link_if.channel link
);
   logic [7:0]       ctrl, next_ctrl;
   logic [2:0]       clk_sync, next_clk_sync;
   logic [1:0]       dat_sync, next_dat_sync;
   logic             bit_q, next_bit_q;
   logic             bit_v, next_bit_v;
   logic [ACC_W-1:0] fill, next_fill;
   logic [15:0]      phase_acc, next_phase_acc;
   logic             out_d, next_out_d;
   logic             out_s, next_out_s;
   logic [7:0]       gap_run, next_gap_run;
   logic [7:0]       pulse_cnt, next_pulse_cnt;
   logic [31:0]      relock, next_relock;
   logic [7:0]       rdata, next_rdata;
   // bit store deep enough for long gaps followed by bursts
   localparam int    BUF_W = 7;
   localparam int    DEPTH = 2 ** BUF_W;
   logic [DEPTH-1:0] bit_store, next_bit_store;
   logic [BUF_W-1:0] wr_ptr, next_wr_ptr;
   logic [BUF_W-1:0] rd_ptr, next_rd_ptr;
   logic             fast_on;
   logic             rise;
   logic             emit;
   logic             narrow;

   always_comb begin
      next_ctrl      = ctrl;
      next_clk_sync  = {clk_sync[1:0], link.tx_gapped_clock_in};
      next_dat_sync  = {dat_sync[0], link.tx_positive_data_in};
      // edge seen only between second and third stage
      rise           = clk_sync[1] && !clk_sync[2];
      next_bit_q     = bit_q;
      next_bit_v     = 1'b0;
      // [RULE11] pins keep fast relock on
      fast_on        = !(host_mode_i && ctrl[BIT_RELOCK_DIS]);
      // [RULE16] narrow bandwidth setting
      narrow         = {ctrl[BIT_BW_HI], ctrl[BIT_BW_LO]} == BW_NARROW;
      next_fill      = fill;
      next_bit_store = bit_store;
      next_wr_ptr    = wr_ptr;
      next_rd_ptr    = rd_ptr;
      // product exceeds 31 bits, so work it out wide
      next_phase_acc = phase_acc + 16'((longint'(DS3_KHZ) * 65536) / (CLK_MHZ * 1000));
      emit           = phase_acc > next_phase_acc;
      next_out_d     = out_d;
      next_out_s     = 1'b0;
      next_gap_run   = gap_run;
      next_pulse_cnt = pulse_cnt;
      next_relock    = relock;
      next_rdata     = 8'h00;
      // [RULE12] write masks read-only top bits
      if (wr_i && addr_i == CTRL_OFFSET) begin
         next_ctrl = wdata_i & CTRL_RW_MASK;
      end
      // [RULE15] sample data on rising edge
      if (rise) begin
         next_bit_q     = dat_sync[1];
         next_bit_v     = 1'b1;
         next_gap_run   = 8'h00;
         next_pulse_cnt = pulse_cnt + 8'h01;
      end else if (gap_run != 8'hFF) begin
         next_gap_run = gap_run + 8'h01;
      end
      // [RULE9] [RULE10] elastic fill absorbs long gaps
      if (bit_v) begin
         next_bit_store[wr_ptr] = bit_q;
         next_wr_ptr            = wr_ptr + BUF_W'(1);
      end
      if (emit && fill != '0) begin
         next_rd_ptr = rd_ptr + BUF_W'(1);
      end
      if (bit_v && !(emit && fill != '0)) begin
         next_fill = fill + ACC_W'(1);
      end else if (!bit_v && emit && fill != '0) begin
         next_fill = fill - ACC_W'(1);
      end
      if (emit && fill != '0 && ctrl[BIT_IN_TX_PATH]) begin
         next_out_d = bit_store[rd_ptr];
         next_out_s = 1'b1;
      end else if (bit_v && !ctrl[BIT_IN_TX_PATH]) begin
         next_out_d = bit_q;
         next_out_s = 1'b1;
      end
      // [RULE13] reacquire bound by fast mode
      if (protect_switch_i) begin
         next_relock = fast_on ? 32'(RELOCK_FAST) : 32'(RELOCK_SLOW);
      end else if (relock != 32'h0) begin
         next_relock = relock - 32'h1;
      end
      if (ctrl[BIT_BUF_CLEAR] || (narrow && protect_switch_i && fast_on)) begin
         next_fill   = '0;
         next_rd_ptr = next_wr_ptr;
      end
      if (rd_i) begin
         unique case (addr_i)
            CTRL_OFFSET:   next_rdata = ctrl;
            STATUS_OFFSET: next_rdata = {5'h00, fast_on, narrow, relock == 32'h0};
            COUNT_OFFSET:  next_rdata = pulse_cnt;
            default:       next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctrl      <= CTRL_RESET;
         clk_sync  <= 3'h0;
         dat_sync  <= 2'h0;
         bit_q     <= 1'b0;
         bit_v     <= 1'b0;
         fill      <= '0;
         bit_store <= '0;
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         phase_acc <= 16'h0000;
         out_d     <= 1'b0;
         out_s     <= 1'b0;
         gap_run   <= 8'h00;
         pulse_cnt <= 8'h00;
         relock    <= 32'h0;
         rdata     <= 8'h00;
      end else begin
         ctrl      <= next_ctrl;
         clk_sync  <= next_clk_sync;
         dat_sync  <= next_dat_sync;
         bit_q     <= next_bit_q;
         bit_v     <= next_bit_v;
         fill      <= next_fill;
         bit_store <= next_bit_store;
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         phase_acc <= next_phase_acc;
         out_d     <= next_out_d;
         out_s     <= next_out_s;
         gap_run   <= next_gap_run;
         pulse_cnt <= next_pulse_cnt;
         relock    <= next_relock;
         rdata     <= next_rdata;
      end
   end

   assign rdata_o      = rdata;
   assign ds3_data_o   = out_d;
   assign ds3_strobe_o = out_s;
   assign locked_o     = relock == 32'h0;
endmodule
`default_nettype wire

// ### dv/desync_link_monitor.sv
`default_nettype none
module desync_link_monitor #(
   parameter int DIV = 2
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic tx_gapped_clock_in,
   input wire logic tx_positive_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_q;
   logic        started;
   logic        full;
   logic        rise;
   logic        gap_rise;
   int unsigned since, run, prev_len, sevens, fives, majors, pulses, cycles;
   // edges found by sampling, as the channel does
   assign rise     = tx_gapped_clock_in & ~clk_q;
   assign gap_rise = rise & started & (since == 4 * DIV - 1);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         clk_q    <= 1'b0;
         started  <= 1'b0;
         full     <= 1'b0;
         {since, run, prev_len, sevens, fives, majors, pulses, cycles} <= '0;
      end else begin
         clk_q  <= tx_gapped_clock_in;
         since  <= rise ? 0 : since + 1;
         cycles <= cycles + 1;
         if (rise) begin
            started <= 1'b1;
            run     <= run + 1;
            pulses  <= pulses + 1;
         end
         // a gap-less six runs into the next seven, hence 13
         if (gap_rise) begin
            run      <= 1;
            prev_len <= run;
            sevens   <= (run == 13) ? 1 : (run == 7) ? sevens + 1 : 0;
            fives    <= (run == 5) ? fives + 1 : 0;
            majors   <= (run == 13) ? 0 : (run == 7 && prev_len == 5) ? majors + 1 : majors;
         end
         if (gap_rise && run == 13) begin
            full   <= 1'b1;
            pulses <= 1;
            cycles <= 1;
         end
      end
   end
   a_pulse_spacing : assert property ( // one period or one gap
      rise && started |-> since == 2 * DIV - 1 || since == 4 * DIV - 1)
      else $error("link clock spacing wrong");
   a_burst_length : assert property ( // burst sizes
      gap_rise |-> run == 7 || run == 5 || run == 13) else $error("burst length wrong");
   a_seven_repeats : assert property ( // sevens per major
      gap_rise && run == 5 && prev_len == 7 |-> sevens == 63) else $error("seven count wrong");
   a_five_repeats_a : assert property ( // fives in first major
      gap_rise && run == 7 && prev_len == 5 |-> fives == 36) else $error("five count wrong");
   a_five_repeats_b : assert property ( // fives in second major
      gap_rise && run == 13 |-> fives == 35) else $error("five count before six wrong");
   a_major_order : assert property ( // two first majors then one second
      gap_rise && run == 13 |-> majors == 2) else $error("major order wrong");
   a_super_totals : assert property ( // pulses and periods per super
      gap_rise && run == 13 && full |-> pulses == 1864 && cycles == 2160 * 2 * DIV)
      else $error("super pattern totals wrong");
   a_data_steady : assert property ( // data moves only with a pulse
      !rise |-> $stable(tx_positive_data_in)) else $error("data changed without pulse");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top import desync_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       enable_i = 1'b0;
   logic       data_i = 1'b0;
   logic       host_mode_i = 1'b0;
   logic       protect_switch_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic       data_taken_o, super_start_o, ds3_data_o, ds3_strobe_o, locked_o, b;
   logic       chk_on = 1'b0;
   logic       q[$];
   logic [7:0] d;
   int         failures = 0;
   int         total_checks = 0;
   int         sent = 0;
   int         sc = 0;
   int         starts = 0;
   always #5 core_clk_i = ~core_clk_i;
   desync_link_if link_if ();
   // 80 ns link period keeps a full super under 18k cycles
   super_pattern_gen #(.DIV(4)) super_pattern_gen_inst (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .enable_i(enable_i), .data_i(data_i), .data_taken_o(data_taken_o),
      .super_start_o(super_start_o), .link(link_if));
   desync_channel #(.RELOCK_FAST(20), .RELOCK_SLOW(200)) desync_channel_inst (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .host_mode_i(host_mode_i),
      .protect_switch_i(protect_switch_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .ds3_data_o(ds3_data_o), .ds3_strobe_o(ds3_strobe_o),
      .locked_o(locked_o), .link(link_if));
   desync_link_monitor #(.DIV(4)) link_mon (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .tx_gapped_clock_in(link_if.tx_gapped_clock_in),
      .tx_positive_data_in(link_if.tx_positive_data_in));
   always @(posedge core_clk_i) begin
      if (data_taken_o) begin
         q.push_back(data_i);
         sent <= sent + 1;
         data_i <= sent[0] ^ sent[2];
      end
      if (ds3_strobe_o && chk_on) begin
         // a strobe with nothing sent must not pass unseen
         b = 1'bx;
         if (q.size() > 0) b = q.pop_front();
         `CHK("ds3 bit", b, ds3_data_o) // bits pass in order
      end
      if (srst_i) begin
         starts <= 0;
      end else if (super_start_o) begin
         if (starts > 0) `CHK("super pulses", SUPER_PULSES, sc) // pulses per super
         starts <= starts + 1;
      end
      sc <= super_start_o ? int'(data_taken_o) : sc + int'(data_taken_o);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      d = rdata_o;
   endtask
   task automatic switch_event();
      @(posedge core_clk_i);
      protect_switch_i <= 1'b1;
      @(posedge core_clk_i);
      protect_switch_i <= 1'b0;
   endtask
   task automatic test_regs();
      rd(CTRL_OFFSET);
      `CHK("ctrl reset", CTRL_RESET, d) // reset value
      wr(CTRL_OFFSET, 8'hFF);
      rd(CTRL_OFFSET);
      `CHK("ctrl bits", CTRL_RW_MASK, d) // top bits stay zero
      rd(8'h00);
      `CHK("unmapped", 8'h00, d) // nothing outside the map
      rd(STATUS_OFFSET);
      `CHK("fast pin mode", 1'b1, d[2]) // pin mode keeps fast relock
      @(posedge core_clk_i);
      host_mode_i <= 1'b1;
      rd(STATUS_OFFSET);
      `CHK("fast off", 1'b0, d[2]) // register may turn it off
      wr(CTRL_OFFSET, 8'h03);
      rd(STATUS_OFFSET);
      `CHK("narrow fast", 2'b11, d[2:1]) // narrow setting
      $display("test_regs done");
   endtask
   task automatic test_relock();
      switch_event();
      @(negedge core_clk_i);
      `CHK("lock dropped", 1'b0, locked_o) // switch starts relock
      repeat (30) @(negedge core_clk_i);
      `CHK("fast relock", 1'b1, locked_o) // relock in short window
      wr(CTRL_OFFSET, 8'h13);
      switch_event();
      repeat (30) @(negedge core_clk_i);
      `CHK("slow pending", 1'b0, locked_o) // disable honoured
      repeat (200) @(negedge core_clk_i);
      `CHK("slow relock", 1'b1, locked_o) // slow path still ends
      $display("test_relock done");
   endtask
   task automatic test_stream();
      wr(CTRL_OFFSET, 8'h01);
      @(posedge core_clk_i);
      chk_on <= 1'b1;
      enable_i <= 1'b1;
      wait (starts == 3);
      // run past the next six-seven run so the monitor judges the totals once
      repeat (150) @(posedge core_clk_i);
      enable_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      chk_on <= 1'b0;
      rd(COUNT_OFFSET);
      `CHK("pulse count", sent[7:0], d) // every pulse sampled
      `CHK("bits left", 0, q.size()) // all bits passed on
      $display("test_stream done");
   endtask
   task automatic test_smooth();
      int base;
      // mid-run reset, then the same stream through the bit store
      @(posedge core_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      srst_i <= 1'b0;
      base = sent;
      rd(CTRL_OFFSET);
      `CHK("ctrl after reset", CTRL_RESET, d) // reset value again
      wr(CTRL_OFFSET, 8'h03);
      @(posedge core_clk_i);
      chk_on <= 1'b1;
      enable_i <= 1'b1;
      repeat (3000) @(posedge core_clk_i);
      enable_i <= 1'b0;
      repeat (40) @(posedge core_clk_i);
      chk_on <= 1'b0;
      rd(COUNT_OFFSET);
      `CHK("smoothed count", 8'(sent - base), d) // pulses after reset
      `CHK("smoothed left", 0, q.size()) // buffered bits all out
      $display("test_smooth done");
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      srst_i <= 1'b0;
      test_regs();
      test_relock();
      test_stream();
      test_smooth();
      test_done();
   end
   initial begin
      #1ms;
      failures++;
      test_done();
   end
endmodule
`default_nettype wire
